// ===== idrb_top.sv
`include "idrb_cfg.svh"
`default_nettype none
module idrb_top
  import idrb_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_ce,
  input  wire logic        i_req,
  input  wire idrb_mode_e  i_mode,
  input  wire logic        i_we,
  input  wire logic [7:0]  i_addr,
  input  wire logic [7:0]  i_wdata,
  input  wire idrb_bitop_e i_bitop,
  input  wire logic        i_sp_we,
  input  wire logic [7:0]  i_sp_wdata,
  input  wire logic        i_psw_we,
  input  wire logic [7:0]  i_psw_wdata,
  output logic             o_ack,
  output logic             o_err,
  output logic [7:0]       o_rdata,
  output logic             o_rbit,
  output logic [7:0]       o_stack_pointer,
  output logic [7:0]       o_program_status_word,
  output logic [1:0]       o_bank
);
  typedef enum logic [1:0] {IDRB_IDLE, IDRB_PTR, IDRB_RD, IDRB_WB} idrb_st_e;

  idrb_st_e   st_r;
  idrb_mode_e mode_r;
  idrb_bitop_e bitop_r;
  logic       we_r;
  logic [7:0] addr_r;
  logic [7:0] wdata_r;
  logic [2:0] bitsel_r;
  logic [7:0] sp_r;
  logic [7:0] psw_r;
  logic [7:0] ram_addr;
  logic [7:0] ram_wdata;
  logic       ram_we;
  logic [7:0] ram_rdata;
  logic [7:0] bank_base;
  logic       bad;
  logic [7:0] bit_byte;

  assign bank_base = {3'h0, psw_r[`IDRB_PSW_BSH], psw_r[`IDRB_PSW_BSL], 3'h0};
  // Bit address: bits 6:3 pick a byte from 20H up, low three the bit
  assign bit_byte  = `IDRB_BIT_BASE + {4'h0, i_addr[6:3]};
  assign bad = i_req && (((i_mode == IDRB_M_DIRECT) && (i_addr > `IDRB_DIRECT_TOP))
              || ((i_mode == IDRB_M_BIT) && i_addr[7])
              || ((i_mode == IDRB_M_BANKREG) && (i_addr > 8'h07)));

  // Register file reached by every method
  idrb_ram #(.DEPTH(`IDRB_RAM_DEPTH), .WIDTH(`IDRB_DATA_W)) u_ram (
    .i_clk   (i_clk),
    .i_ce    (i_ce),
    .i_we    (ram_we),
    .i_addr  (ram_addr),
    .i_wdata (ram_wdata),
    .o_rdata (ram_rdata)
  );

  always_comb begin
    ram_addr  = 8'h00;
    ram_we    = 1'b0;
    ram_wdata = wdata_r;
    unique case (st_r)
      IDRB_IDLE: begin
        ram_we = 1'b0;
        ram_wdata = i_wdata;
        if (i_req && !bad) begin
          unique case (i_mode)
            IDRB_M_BANKREG:  ram_addr = bank_base | {5'h0, i_addr[2:0]};
            IDRB_M_INDIRECT: ram_addr = bank_base | {7'h0, i_addr[0]};
            IDRB_M_DIRECT:   ram_addr = i_addr;
            IDRB_M_BIT:      ram_addr = bit_byte;
            IDRB_M_PUSH:     ram_addr = sp_r + 8'h01;
            IDRB_M_POP:      ram_addr = sp_r;
            default:         ram_addr = 8'h00;
          endcase
          ram_we = i_we && (i_mode inside {IDRB_M_BANKREG, IDRB_M_DIRECT, IDRB_M_PUSH});
        end
      end
      IDRB_PTR: begin
        // Pointer value just read; now open the pointed location
        ram_addr = ram_rdata;
        ram_we   = we_r;
      end
      IDRB_RD: begin
        ram_addr = addr_r;
      end
      IDRB_WB: begin
        ram_addr = addr_r;
        ram_we   = 1'b1;
        unique case (bitop_r)
          IDRB_B_CLR: ram_wdata = wdata_r & ~(8'h01 << bitsel_r);
          IDRB_B_SET: ram_wdata = wdata_r | (8'h01 << bitsel_r);
          IDRB_B_CPL: ram_wdata = wdata_r ^ (8'h01 << bitsel_r);
          IDRB_B_READ: ram_wdata = wdata_r;
        endcase
      end
    endcase
  end

  // Sequencer: two cycles (IDLE then RD) for plain accesses, one extra cycle for pointer
  // fetch and one for bit read-modify-write
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      st_r    <= IDRB_IDLE;
      mode_r  <= IDRB_M_DIRECT;
      bitop_r <= IDRB_B_READ;
      we_r    <= 1'b0;
      addr_r  <= 8'h00;
      wdata_r <= 8'h00;
      bitsel_r <= 3'h0;
    end else if (i_ce) begin
      unique case (st_r)
        IDRB_IDLE: if (i_req && !bad) begin
          mode_r   <= i_mode;
          bitop_r  <= i_bitop;
          we_r     <= i_we;
          wdata_r  <= i_wdata;
          addr_r   <= ram_addr;
          bitsel_r <= i_addr[2:0];
          if (i_mode == IDRB_M_INDIRECT) st_r <= IDRB_PTR;
          else st_r <= IDRB_RD;
        end
        IDRB_PTR: begin
          addr_r <= ram_rdata;
          st_r   <= IDRB_RD;
        end
        IDRB_RD: begin
          if (mode_r == IDRB_M_BIT && bitop_r != IDRB_B_READ) begin
            wdata_r <= ram_rdata;
            st_r    <= IDRB_WB;
          end else begin
            st_r <= IDRB_IDLE;
          end
        end
        IDRB_WB: st_r <= IDRB_IDLE;
      endcase
    end
  end

  // Stack pointer: software load wins over push/pop in the same cycle
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      sp_r <= `IDRB_SP_RESET;
    end else if (i_ce) begin
      if (i_sp_we) begin
        sp_r <= i_sp_wdata;
      end else if (st_r == IDRB_IDLE && i_req && !bad && i_mode == IDRB_M_PUSH) begin
        sp_r <= sp_r + 8'h01;
      end else if (st_r == IDRB_IDLE && i_req && !bad && i_mode == IDRB_M_POP) begin
        sp_r <= sp_r - 8'h01;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      psw_r <= `IDRB_PSW_RESET;
    end else if (i_ce && i_psw_we) begin
      psw_r <= i_psw_wdata;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_rdata <= 8'h00;
      o_rbit  <= 1'b0;
      o_ack   <= 1'b0;
      o_err   <= 1'b0;
    end else if (i_ce) begin
      o_ack <= 1'b0;
      o_err <= (st_r == IDRB_IDLE) && bad;
      if (st_r == IDRB_RD) begin
        o_rdata <= ram_rdata;
        o_rbit  <= ram_rdata[bitsel_r];
        o_ack   <= !(mode_r == IDRB_M_BIT && bitop_r != IDRB_B_READ);
      end else if (st_r == IDRB_WB) begin
        o_ack <= 1'b1;
      end
    end
  end

  assign o_stack_pointer       = sp_r;
  assign o_program_status_word = psw_r;
  assign o_bank = {psw_r[`IDRB_PSW_BSH], psw_r[`IDRB_PSW_BSL]};

  a_sp_reset: assert property (@(posedge i_clk) $rose(i_rst_n) |-> sp_r == 8'h07)
    else $error("stack pointer not 07 after reset");
  a_push_incr: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_ce && st_r == IDRB_IDLE && i_req && !bad && i_mode == IDRB_M_PUSH && !i_sp_we)
    |=> sp_r == $past(sp_r) + 8'h01) else $error("push did not increment");
  a_sp_write: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_ce && i_sp_we) |=> sp_r == $past(i_sp_wdata)) else $error("sp load lost");
  a_direct_high: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_ce && st_r == IDRB_IDLE && i_req && i_mode == IDRB_M_DIRECT && i_addr[7])
    |=> o_err && st_r == IDRB_IDLE) else $error("direct upper half not refused");
  a_bank_map: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (st_r == IDRB_IDLE && i_req && !bad && i_mode == IDRB_M_BANKREG)
    |-> ram_addr == {3'h0, psw_r[4], psw_r[3], i_addr[2:0]})
    else $error("bank map wrong");
  a_bit_byte: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (st_r == IDRB_IDLE && i_req && !bad && i_mode == IDRB_M_BIT)
    |-> ram_addr >= 8'h20 && ram_addr <= 8'h2f) else $error("bit byte out of area");
  a_direct_low: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_ce && st_r == IDRB_IDLE && i_req && i_mode == IDRB_M_DIRECT && !i_addr[7])
    |=> st_r == IDRB_RD ##1 o_ack) else $error("direct access did not complete");
  a_indir_seq: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_ce && st_r == IDRB_IDLE && i_req && i_mode == IDRB_M_INDIRECT)
    |=> st_r == IDRB_PTR) else $error("indirect skipped pointer fetch");
endmodule
`default_nettype wire

// ===== idrb_cfg.svh
`ifndef IDRB_CFG_SVH
`define IDRB_CFG_SVH
`define IDRB_RAM_DEPTH      256
`define IDRB_DATA_W         8
`define IDRB_BANK_BASE_W    8'h00
`define IDRB_BANK_TOP       8'h1f
`define IDRB_BIT_BASE       8'h20
`define IDRB_BIT_TOP        8'h2f
`define IDRB_DIRECT_TOP     8'h7f
`define IDRB_SP_ADDR        8'h81
`define IDRB_SP_RESET       8'h07
`define IDRB_PSW_RESET      8'h00
`define IDRB_PSW_CY         7
`define IDRB_PSW_AC         6
`define IDRB_PSW_F0         5
`define IDRB_PSW_BSH        4
`define IDRB_PSW_BSL        3
`define IDRB_PSW_OV         2
`define IDRB_PSW_F1         1
`define IDRB_PSW_P          0
`endif

// ===== idrb_pkg.sv
`default_nettype none
package idrb_pkg;
  // Access method presented by the core with each request
  typedef enum logic [2:0] {
    IDRB_M_BANKREG,
    IDRB_M_INDIRECT,
    IDRB_M_DIRECT,
    IDRB_M_BIT,
    IDRB_M_PUSH,
    IDRB_M_POP
  } idrb_mode_e;
  // Bit operation for single-bit accesses
  typedef enum logic [1:0] {
    IDRB_B_READ,
    IDRB_B_CLR,
    IDRB_B_SET,
    IDRB_B_CPL
  } idrb_bitop_e;
  typedef logic [7:0] idrb_byte_t;
endpackage
`default_nettype wire

// ===== idrb_ram.sv
`include "idrb_cfg.svh"
`default_nettype none
module idrb_ram #(
  parameter int DEPTH = `IDRB_RAM_DEPTH,
  parameter int WIDTH = `IDRB_DATA_W
) (
  input  wire logic                     i_clk,
  input  wire logic                     i_ce,
  input  wire logic                     i_we,
  input  wire logic [$clog2(DEPTH)-1:0] i_addr,
  input  wire logic [WIDTH-1:0]         i_wdata,
  output logic      [WIDTH-1:0]         o_rdata
);
  if (DEPTH < 2 || WIDTH < 1) begin : g_bad_geometry
    $error("idrb_ram: bad geometry");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  // Contents are undefined after reset, as the core expects
  always_ff @(posedge i_clk) begin
    if (i_ce) begin
      if (i_we) begin
        mem[i_addr] <= i_wdata;
      end
      o_rdata <= mem[i_addr];
    end
  end
endmodule
`default_nettype wire

// ===== idrb_core.sv
`default_nettype none
module idrb_core
  import idrb_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_ack,
  input  wire logic        i_err,
  input  wire logic [7:0]  i_rdata,
  input  wire logic        i_rbit,
  output var  logic        o_req,
  output var  idrb_mode_e  o_mode,
  output var  logic        o_we,
  output var  logic [7:0]  o_addr,
  output var  logic [7:0]  o_wdata,
  output var  idrb_bitop_e o_bitop,
  output var  logic        o_sp_we,
  output var  logic [7:0]  o_sp_wdata,
  output var  logic        o_psw_we,
  output var  logic [7:0]  o_psw_wdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] rd;
  logic       rb;
  logic       er;
  initial begin
    {o_req, o_we, o_sp_we, o_psw_we} = 4'h0;
    o_mode = IDRB_M_DIRECT;
    o_bitop = IDRB_B_READ;
    {o_addr, o_wdata, o_sp_wdata, o_psw_wdata} = 32'h0;
  end
  // Held until the answer or for eight cycles; released address and data invert so stale values never match
  task automatic xfer(input idrb_mode_e m, input logic w, input logic [7:0] a, d,
                      input idrb_bitop_e b);
    int n;
    @(negedge i_clk);
    o_mode = m;
    o_bitop = b;
    {o_req, o_we, o_addr, o_wdata} = {1'b1, w, a, d};
    n = 0;
    do begin
      @(negedge i_clk);
      n++;
    end while (i_ack !== 1'b1 && i_err !== 1'b1 && n < 8);
    {rd, rb} = {i_rdata, i_rbit};
    er = (n < 8) ? i_err : 1'bx;
    {o_req, o_we, o_addr, o_wdata} = {1'b0, 1'b0, ~a, ~d};
  endtask
  task automatic load(input logic sp, input logic [7:0] v);
    @(negedge i_clk);
    {o_sp_we, o_psw_we, o_sp_wdata, o_psw_wdata} = {sp, !sp, v, v};
    @(negedge i_clk);
    {o_sp_we, o_psw_we, o_sp_wdata, o_psw_wdata} = {2'b00, ~v, ~v};
  endtask
endmodule
`default_nettype wire

// ===== tb_top.sv
`default_nettype none
module tb_top
  import idrb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        i_clk = 1'b0;
  logic        i_rst_n = 1'b0;
  logic        i_ce = 1'b1;
  logic        req, we, sp_we, psw_we, ack, err, rbit;
  logic [7:0]  addr, wdata, spd, pswd, rdata, sp, program_status_word;
  logic [1:0]  bank;
  idrb_mode_e  mode;
  idrb_bitop_e bop;
  int          n_errors = 0;
  int          tests_run = 0;
  always #20 i_clk = ~i_clk;
  idrb_top u_idrb_top (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(i_ce), .i_req(req),
    .i_mode(mode), .i_we(we), .i_addr(addr), .i_wdata(wdata), .i_bitop(bop),
    .i_sp_we(sp_we), .i_sp_wdata(spd), .i_psw_we(psw_we), .i_psw_wdata(pswd),
    .o_ack(ack), .o_err(err), .o_rdata(rdata), .o_rbit(rbit), .o_stack_pointer(sp),
    .o_program_status_word(program_status_word), .o_bank(bank));
  idrb_core u_idrb_core (.i_clk(i_clk), .i_ack(ack), .i_err(err), .i_rdata(rdata),
    .i_rbit(rbit), .o_req(req), .o_mode(mode), .o_we(we), .o_addr(addr),
    .o_wdata(wdata), .o_bitop(bop), .o_sp_we(sp_we), .o_sp_wdata(spd),
    .o_psw_we(psw_we), .o_psw_wdata(pswd));
  task automatic chk8(input logic [7:0] g, e);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk1(input logic g, e);
    chk8({7'h0, g}, {7'h0, e});
  endtask
  task automatic x(input idrb_mode_e m, input logic w, input logic [7:0] a, d = 8'h00,
                   input idrb_bitop_e b = IDRB_B_READ);
    u_idrb_core.xfer(m, w, a, d, b);
    if (u_idrb_core.er === 1'bx) begin
      n_errors++;
      $display("mismatch at %0t: no answer from the block", $time);
    end
  endtask
  // Read back with a given method and compare the byte
  task automatic rdx(input idrb_mode_e m, input logic [7:0] a, e);
    x(m, 1'b0, a);
    chk8(u_idrb_core.rd, e);
  endtask
  task automatic bad(input idrb_mode_e m, input logic [7:0] a);
    x(m, 1'b1, a, 8'h11, IDRB_B_SET);
    chk1(u_idrb_core.er, 1'b1);
  endtask
  task automatic t_reset;
    chk8(sp, 8'h07);
    chk8(program_status_word, 8'h00);
  endtask
  task automatic t_direct;
    x(IDRB_M_DIRECT, 1'b1, 8'h00, 8'h3c);
    x(IDRB_M_DIRECT, 1'b1, 8'h7f, 8'hc3);
    rdx(IDRB_M_DIRECT, 8'h00, 8'h3c);
    rdx(IDRB_M_DIRECT, 8'h7f, 8'hc3);
    bad(IDRB_M_DIRECT, 8'h80);
    bad(IDRB_M_BANKREG, 8'h08);
  endtask
  task automatic t_bank;
    for (int b = 0; b < 4; b++) begin
      u_idrb_core.load(1'b0, 8'h81 | 8'(b << 3));
      chk8({6'h0, bank}, 8'(b));
      x(IDRB_M_BANKREG, 1'b1, 8'h07, 8'h50 + 8'(b));
    end
    rdx(IDRB_M_BANKREG, 8'h07, 8'h53);
    for (int b = 0; b < 4; b++) rdx(IDRB_M_DIRECT, 8'(b * 8 + 7), 8'h50 + 8'(b));
  endtask
  task automatic t_indirect;
    u_idrb_core.load(1'b0, 8'h00);
    x(IDRB_M_BANKREG, 1'b1, 8'h00, 8'hff);
    x(IDRB_M_BANKREG, 1'b1, 8'h01, 8'h80);
    x(IDRB_M_INDIRECT, 1'b1, 8'h00, 8'ha5);
    x(IDRB_M_INDIRECT, 1'b1, 8'h01, 8'h5a);
    rdx(IDRB_M_INDIRECT, 8'h00, 8'ha5);
    rdx(IDRB_M_INDIRECT, 8'h01, 8'h5a);
    x(IDRB_M_BANKREG, 1'b1, 8'h00, 8'h07);
    rdx(IDRB_M_INDIRECT, 8'h00, 8'h50);
  endtask
  task automatic t_bit;
    x(IDRB_M_DIRECT, 1'b1, 8'h2f, 8'hff);
    x(IDRB_M_DIRECT, 1'b1, 8'h20, 8'h00);
    x(IDRB_M_BIT, 1'b0, 8'h7f, 8'h00, IDRB_B_CLR);
    x(IDRB_M_BIT, 1'b0, 8'h00, 8'h00, IDRB_B_SET);
    x(IDRB_M_BIT, 1'b0, 8'h07, 8'h00, IDRB_B_CPL);
    rdx(IDRB_M_DIRECT, 8'h2f, 8'h7f);
    rdx(IDRB_M_DIRECT, 8'h20, 8'h81);
    x(IDRB_M_BIT, 1'b0, 8'h7e);
    chk1(u_idrb_core.rb, 1'b1);
    bad(IDRB_M_BIT, 8'h80);
  endtask
  task automatic t_stack;
    u_idrb_core.load(1'b1, 8'h7f);
    x(IDRB_M_PUSH, 1'b1, 8'h00, 8'h34);
    x(IDRB_M_PUSH, 1'b1, 8'h00, 8'h12);
    chk8(sp, 8'h81);
    x(IDRB_M_BANKREG, 1'b1, 8'h00, 8'h80);
    rdx(IDRB_M_INDIRECT, 8'h00, 8'h34);
    rdx(IDRB_M_POP, 8'h00, 8'h12);
    rdx(IDRB_M_POP, 8'h00, 8'h34);
    chk8(sp, 8'h7f);
  endtask
  // Clock enable low must freeze the registers; a mid-run reset restores them
  task automatic t_freeze;
    @(negedge i_clk);
    i_ce = 1'b0;
    u_idrb_core.load(1'b1, 8'h42);
    chk8(sp, 8'h7f);
    u_idrb_core.load(1'b0, 8'h18);
    chk8({6'h0, bank}, 8'h00);
    i_ce = 1'b1;
    u_idrb_core.load(1'b0, 8'h18);
    i_rst_n = 1'b0;
    @(negedge i_clk);
    i_rst_n = 1'b1;
    chk8(sp, 8'h07);
    chk8(program_status_word, 8'h00);
  endtask
  task automatic results;
    $display("errors %0d, checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (3) @(negedge i_clk);
    i_rst_n = 1'b1;
    t_reset();
    t_direct();
    t_bank();
    t_indirect();
    t_bit();
    t_stack();
    t_freeze();
    results();
  end
  initial begin
    #200000;
    n_errors++;
    results();
  end
endmodule
`default_nettype wire
